// ==== core/sch_pkg.sv ====
package sch_pkg;
    // ======================================================================
    // frame geometry
    localparam int          FRAME_SAMPLES   = 160;
    localparam int          SUBFRAMES       = 4;
    localparam int          PULSES          = 13;
    localparam int          LAR_COUNT       = 8;
    localparam int          LTP_HIST        = 121;
    localparam int          PARAM_COUNT     = 76;
    localparam int          PARAMS_FIRST    = 25;
    localparam int          SUB_STRIDE      = 17;
    localparam int          SUB_BASE        = 8;
    localparam int          PULSE_OFS       = 4;
    // ======================================================================
    // homing patterns
    localparam logic [15:0] ENC_HOME_SAMPLE = 16'h0008;
    localparam logic [15:0] HOME_LAG        = 16'h0028;
    localparam logic [15:0] HOME_PULSE      = 16'h0004;
    localparam logic [15:0] HOME_PULSE_ALT  = 16'h0003;
    localparam int          ALT_SUB         = 3;
    localparam int          ALT_PULSE       = 4;
    localparam logic [15:0] HOME_ZERO       = 16'h0000;
    localparam logic [15:0] DEC_PREV_LAG    = 16'h0028;
    // ======================================================================
    // de-emphasis, reset values and buffer sizes
    localparam logic signed [15:0] DEEMPH_BETA = 16'sh6E14;
    localparam int          DEEMPH_SHIFT    = 15;
    localparam logic [7:0]  CNT_RESET       = 8'h00;
    localparam logic        HOMED_RESET     = 1'b1;
    localparam int          FIFO_DEPTH      = 8;
    localparam int          WORD_W          = 16;

    function automatic logic [15:0] sch_lar_home(input int idx);
        case (idx)
            0:       sch_lar_home = 16'h0009;
            1:       sch_lar_home = 16'h0017;
            2:       sch_lar_home = 16'h000F;
            3:       sch_lar_home = 16'h0008;
            4:       sch_lar_home = 16'h0007;
            5:       sch_lar_home = 16'h0003;
            6:       sch_lar_home = 16'h0003;
            default: sch_lar_home = 16'h0002;
        endcase
    endfunction : sch_lar_home

    // expected value of parameter word idx in the decoder homing frame
    function automatic logic [15:0] sch_dec_home_word(input int idx);
        int sub;
        int pos;
        sub = 0;
        pos = 0;
        if (idx < SUB_BASE) begin
            sch_dec_home_word = sch_lar_home(idx);
        end else begin
            sub = (idx - SUB_BASE) / SUB_STRIDE;
            pos = (idx - SUB_BASE) % SUB_STRIDE;
            if (pos == 0) begin
                sch_dec_home_word = HOME_LAG;
            end else if (pos < PULSE_OFS) begin
                sch_dec_home_word = HOME_ZERO;
            end else if (sub == ALT_SUB && pos - PULSE_OFS == ALT_PULSE) begin
                sch_dec_home_word = HOME_PULSE_ALT;
            end else begin
                sch_dec_home_word = HOME_PULSE;
            end
        end
    endfunction : sch_dec_home_word
endpackage : sch_pkg

// ==== core/sch_top.sv ====
// Overview of operation
// - output equals input plus beta times previous output
// - homing feature included, behaves as specified
// - state reset only after frame fully processed
// - encoder homing pattern: 160 samples of 0008
// - consecutive decoder homing frames yield encoder pattern
// - homing frame log area codes 9,23,15,8,7,3,3,2
// - lag 40, gain grid amplitude zero, all subframes
// - pulses 4, subframe four pulse five is 3
// - encoder detects pattern only frame aligned
// - encoder homed run yields decoder homing frame
// - encoder resets all state after homing frame
// - bad frames never trigger decoder homing
// - homed decoder substitutes encoder homing pattern
// - decoder resets all state after homing frame
// - homed decoder may check first 25 words only
// - encoder clears offset and pre-emphasis memories
// - encoder clears lars, lattice, ltp history
// - transmission state forced to defined home values
// - decoder lag 40, clears history, lars, lattice, deemphasis
`timescale 1ns/10ps

// ==========================================================================
// fifo
module sch_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 8
) (
    input  wire logic         clk,       // clock
    input  wire logic         rstn,      // async reset
    input  wire logic [W-1:0] in_data,   // write data
    input  wire logic         in_valid,  // write valid
    output logic              in_ready,  // not full
    output logic [W-1:0]      out_data,  // head word
    output logic              out_valid, // not empty
    input  wire logic         out_ready  // drain
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    wire           push = in_valid && in_ready;
    wire           pop  = out_valid && out_ready;
    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rp_q];

    always_ff @(posedge clk) begin
        if (push) mem[wp_q] <= in_data;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
            if (pop) rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : sch_fifo

// ==========================================================================
// top
module sch_top
    import sch_pkg::*;
(
    input  wire logic        clk,            // 200 MHz clock
    input  wire logic        rstn,           // async reset, active low
    // encoder side
    input  wire logic [15:0] enc_in_sample,  // speech sample, left justified
    input  wire logic        enc_in_valid,   // sample valid
    input  wire logic        enc_in_first,   // first sample of a frame
    output logic             enc_in_ready,   // encoder accepts sample
    input  wire logic [15:0] enc_core_param, // parameter word from encoder core
    input  wire logic        enc_core_valid, // core word valid
    output logic             enc_core_ready, // fifo has room
    output logic [15:0]      enc_out_param,  // parameter word out
    output logic             enc_out_valid,  // parameter valid
    input  wire logic        enc_out_ready,  // channel accepts
    output logic             enc_home_pulse, // one cycle: reset encoder cores
    output logic             enc_homed,      // encoder in home state
    // decoder side
    input  wire logic [15:0] dec_in_param,   // received parameter word
    input  wire logic        dec_in_valid,   // word valid
    input  wire logic        dec_in_bad,     // frame flagged bad
    output logic             dec_in_ready,   // accepts word
    input  wire logic [15:0] dec_synth,      // synthesis filter output
    input  wire logic        dec_synth_valid,// synthesis sample valid
    output logic             dec_synth_ready,// fifo has room
    output logic [15:0]      dec_out_sample, // speech sample out
    output logic             dec_out_valid,  // sample valid
    input  wire logic        dec_out_ready,  // sink accepts
    output logic             dec_home_pulse, // one cycle: reset decoder cores
    output logic [15:0]      dec_prev_lag,   // previous-frame lag state
    output logic             dec_homed       // decoder in home state
);
    import sch_pkg::*;

    // ======================================================================
    // encoder: aligned pattern detection
    logic [7:0]  ein_cnt_q;
    logic        ein_match_q;
    logic        ein_frame_home_q;
    logic        enc_homed_q;
    logic        enc_start_homed_q;
    logic [6:0]  eout_cnt_q;
    logic        ehome_pend_q;
    logic        enc_home_pulse_q;
    wire         ein_take    = enc_in_valid && enc_in_ready;
    wire         ein_pos0    = enc_in_first || (ein_cnt_q == CNT_RESET);
    wire         ein_is_home = (enc_in_sample == ENC_HOME_SAMPLE);
    wire         ein_last    = (ein_cnt_q == 8'(FRAME_SAMPLES-1)) && !enc_in_first;
    wire         ein_match_n = ein_is_home && (ein_pos0 ? 1'b1 : ein_match_q);
    assign enc_in_ready = 1'b1;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ein_cnt_q        <= CNT_RESET;
            ein_match_q      <= 1'b0;
            ein_frame_home_q <= 1'b0;
        end else if (ein_take) begin
            ein_match_q <= ein_match_n;
            ein_cnt_q   <= ein_last ? CNT_RESET : (ein_pos0 ? 8'h01 : ein_cnt_q + 8'h01);
            if (ein_last) ein_frame_home_q <= ein_match_n;
        end
    end

    // ======================================================================
    // encoder output path buffer
    logic [15:0] efifo_data;
    logic        efifo_valid;
    sch_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_efifo (
        .clk       (clk),
        .rstn      (rstn),
        .in_data   (enc_core_param),
        .in_valid  (enc_core_valid),
        .in_ready  (enc_core_ready),
        .out_data  (efifo_data),
        .out_valid (efifo_valid),
        .out_ready (enc_out_ready)
    );
    wire         eout_take = efifo_valid && enc_out_ready;
    wire         eout_last = (eout_cnt_q == 7'(PARAM_COUNT-1));
    wire         eout_first = (eout_cnt_q == 7'h00);
    // homed encoder naturally yields the decoder homing frame; pass through
    assign enc_out_param = efifo_data;
    assign enc_out_valid = efifo_valid;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            eout_cnt_q        <= 7'h00;
            enc_homed_q       <= HOMED_RESET;
            enc_start_homed_q <= HOMED_RESET;
            ehome_pend_q      <= 1'b0;
            enc_home_pulse_q  <= 1'b0;
        end else begin
            enc_home_pulse_q <= 1'b0;
            if (eout_take) begin
                eout_cnt_q <= eout_last ? 7'h00 : eout_cnt_q + 7'h01;
                if (eout_first) enc_start_homed_q <= enc_homed_q;
                // reset only once the frame's last word has left
                if (eout_last && (ehome_pend_q || ein_frame_home_q)) begin
                    enc_home_pulse_q <= 1'b1;
                    enc_homed_q      <= 1'b1;
                    ehome_pend_q     <= 1'b0;
                end else if (eout_last) begin
                    enc_homed_q <= 1'b0;
                end
            end
            // a new homing frame outranks the clear of the old one
            if (ein_take && ein_last && ein_match_n) ehome_pend_q <= 1'b1;
        end
    end
    assign enc_home_pulse = enc_home_pulse_q;
    assign enc_homed      = enc_homed_q;

    // ======================================================================
    // encoder filter memories and transmission state, cleared on homing
    logic signed [15:0] enc_ofs16_q;
    logic signed [31:0] enc_ofs32_q;
    logic signed [15:0] enc_preemph_q;
    logic [1:0]         enc_dtx_state_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            enc_ofs16_q     <= '0;
            enc_ofs32_q     <= '0;
            enc_preemph_q   <= '0;
            enc_dtx_state_q <= 2'h0;
        end else if (enc_home_pulse_q) begin
            enc_ofs16_q     <= '0;
            enc_ofs32_q     <= '0;
            enc_preemph_q   <= '0;
            enc_dtx_state_q <= 2'h0;
        end else if (ein_take) begin
            enc_ofs16_q   <= enc_in_sample;
            enc_ofs32_q   <= enc_ofs32_q + {{16{enc_in_sample[15]}}, enc_in_sample};
            enc_preemph_q <= enc_in_sample;
            if (eout_take && eout_last) enc_dtx_state_q <= enc_dtx_state_q + 2'h1;
        end
    end

    // ======================================================================
    // encoder lars, lattice and ltp history
    logic [15:0] enc_lar_q  [LAR_COUNT];
    logic [15:0] enc_lat_q  [LAR_COUNT];
    logic [15:0] enc_ltp_q  [LTP_HIST];
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < LAR_COUNT; i++) begin
                enc_lar_q[i] <= '0;
                enc_lat_q[i] <= '0;
            end
            for (int i = 0; i < LTP_HIST; i++) enc_ltp_q[i] <= '0;
        end else if (enc_home_pulse_q) begin
            for (int i = 0; i < LAR_COUNT; i++) begin
                enc_lar_q[i] <= '0;
                enc_lat_q[i] <= '0;
            end
            for (int i = 0; i < LTP_HIST; i++) enc_ltp_q[i] <= '0;
        end else if (eout_take) begin
            if (eout_cnt_q < 7'(LAR_COUNT)) enc_lar_q[eout_cnt_q[2:0]] <= efifo_data;
            if (ein_take) enc_lat_q[ein_cnt_q[2:0]] <= enc_in_sample;
            enc_ltp_q[0] <= efifo_data;
            for (int i = 1; i < LTP_HIST; i++) enc_ltp_q[i] <= enc_ltp_q[i-1];
        end
    end

    // ======================================================================
    // decoder: homing frame match
    logic [6:0]  din_cnt_q;
    logic        dmatch_full_q;
    logic        dmatch_early_q;
    logic        dbad_q;
    logic        dec_homed_q;
    logic        dframe_home_q;
    logic        dsubst_q;
    logic [7:0]  dout_cnt_q;
    logic        dec_home_pulse_q;
    logic [15:0] dec_prev_lag_q;
    wire         din_take  = dec_in_valid && dec_in_ready;
    wire         din_last  = (din_cnt_q == 7'(PARAM_COUNT-1));
    wire         din_first = (din_cnt_q == 7'h00);
    wire         din_lag4  = (din_cnt_q == 7'(SUB_BASE + (SUBFRAMES-1) * SUB_STRIDE));
    wire         din_eq    = (dec_in_param == sch_dec_home_word(int'(din_cnt_q)));
    wire         din_full  = din_eq && (din_first || dmatch_full_q);
    wire         din_early = (din_cnt_q < 7'(PARAMS_FIRST)) ? din_full : dmatch_early_q;
    wire         din_bad   = dec_in_bad || (!din_first && dbad_q);
    // a homed decoder only needs the first words
    wire         din_home  = dec_homed_q ? din_early : din_full;
    assign dec_in_ready = 1'b1;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            din_cnt_q      <= 7'h00;
            dmatch_full_q  <= 1'b0;
            dmatch_early_q <= 1'b0;
            dbad_q         <= 1'b0;
            dframe_home_q  <= 1'b0;
            dsubst_q       <= 1'b0;
        end else if (din_take) begin
            din_cnt_q      <= din_last ? 7'h00 : din_cnt_q + 7'h01;
            dmatch_full_q  <= din_full;
            dmatch_early_q <= din_early;
            dbad_q         <= din_bad;
            if (din_last) begin
                dframe_home_q <= din_home && !din_bad;
                dsubst_q      <= din_home && !din_bad && dec_homed_q;
            end
        end
    end

    // ======================================================================
    // decoder output path buffer
    logic [15:0] dfifo_data;
    logic        dfifo_valid;
    logic        dfifo_ready;
    sch_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_dfifo (
        .clk       (clk),
        .rstn      (rstn),
        .in_data   (dec_synth),
        .in_valid  (dec_synth_valid),
        .in_ready  (dec_synth_ready),
        .out_data  (dfifo_data),
        .out_valid (dfifo_valid),
        .out_ready (dfifo_ready)
    );

    // ======================================================================
    // de-emphasis stage
    logic signed [15:0] deemph_q;
    logic signed [15:0] dout_q;
    logic               dout_valid_q;
    wire  signed [31:0] deemph_prod = deemph_q * DEEMPH_BETA;
    wire  signed [16:0] deemph_sum  = 17'(signed'(dfifo_data)) + 17'(deemph_prod >>> DEEMPH_SHIFT);
    wire  signed [15:0] deemph_sat  = (deemph_sum > 17'sh07FFF) ? 16'sh7FFF :
                                      (deemph_sum < -17'sh08000) ? -16'sh8000 : deemph_sum[15:0];
    wire                dout_free   = !dout_valid_q || dec_out_ready;
    wire                dout_take   = dfifo_valid && dout_free;
    wire                dout_last   = (dout_cnt_q == 8'(FRAME_SAMPLES-1));
    assign dfifo_ready = dout_free;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            deemph_q         <= '0;
            dout_q           <= '0;
            dout_valid_q     <= 1'b0;
            dout_cnt_q       <= CNT_RESET;
            dec_homed_q      <= HOMED_RESET;
            dec_home_pulse_q <= 1'b0;
            dec_prev_lag_q   <= DEC_PREV_LAG;
        end else begin
            dec_home_pulse_q <= 1'b0;
            // last sub-frame lag becomes the previous-frame lag
            if (din_take && din_lag4) dec_prev_lag_q <= dec_in_param;
            if (dout_free) dout_valid_q <= dfifo_valid;
            if (dout_take) begin
                deemph_q   <= deemph_sat;
                dout_q     <= dsubst_q ? ENC_HOME_SAMPLE : deemph_sat;
                dout_cnt_q <= dout_last ? CNT_RESET : dout_cnt_q + 8'h01;
                if (dout_last && dframe_home_q) begin
                    dec_home_pulse_q <= 1'b1;
                    dec_homed_q      <= 1'b1;
                    deemph_q         <= '0;
                    dec_prev_lag_q   <= DEC_PREV_LAG;
                end else if (dout_last) begin
                    dec_homed_q <= 1'b0;
                end
            end
        end
    end

    assign dec_out_sample = dout_q;
    assign dec_out_valid  = dout_valid_q;
    assign dec_home_pulse = dec_home_pulse_q;
    assign dec_prev_lag   = dec_prev_lag_q;
    assign dec_homed      = dec_homed_q;
endmodule : sch_top

// ==== testbench/sch_top_assertions.sv ====
`timescale 1ns/10ps

module sch_top_assertions (
    input wire logic        clk,            // clock
    input wire logic        rstn,           // async reset, active low
    input wire logic        enc_in_ready,   // sample ready
    input wire logic [15:0] enc_out_param,  // parameter out
    input wire logic        enc_out_valid,  // parameter valid
    input wire logic        enc_out_ready,  // channel ready
    input wire logic        enc_home_pulse, // encoder homing reset
    input wire logic        enc_homed,      // encoder homed
    input wire logic        dec_in_ready,   // word ready
    input wire logic [15:0] dec_out_sample, // speech out
    input wire logic        dec_out_valid,  // speech valid
    input wire logic        dec_out_ready,  // sink ready
    input wire logic        dec_home_pulse, // decoder homing reset
    input wire logic [15:0] dec_prev_lag,   // previous-frame lag
    input wire logic        dec_homed       // decoder homed
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // ======================================================================
    // homing pulses
    a_enc_pulse_once: assert property (enc_home_pulse |=> !enc_home_pulse)
        else $error("encoder homing pulse longer than one cycle");
    a_dec_pulse_once: assert property (dec_home_pulse |=> !dec_home_pulse)
        else $error("decoder homing pulse longer than one cycle");
    a_enc_home_flag: assert property (enc_home_pulse |-> ##[0:1] enc_homed)
        else $error("encoder not flagged homed after homing");
    a_dec_home_lag: assert property (dec_home_pulse |-> ##[0:1] (dec_homed && dec_prev_lag == 16'h0028))
        else $error("decoder lag or flag wrong after homing");
    a_enc_home_late: assert property (enc_home_pulse |->
        ($past(enc_out_valid && enc_out_ready) || $past(enc_out_valid && enc_out_ready, 2)))
        else $error("encoder homed before last parameter left");
    a_dec_home_late: assert property (dec_home_pulse |->
        ($past(dec_out_valid && dec_out_ready) || $past(dec_out_valid && dec_out_ready, 2)))
        else $error("decoder homed before last sample left");
    // ======================================================================
    // output streams and input readiness
    a_enc_out_hold: assert property (enc_out_valid && !enc_out_ready |=> enc_out_valid && $stable(enc_out_param))
        else $error("parameter changed while stalled");
    a_dec_out_hold: assert property (dec_out_valid && !dec_out_ready |=> dec_out_valid && $stable(dec_out_sample))
        else $error("speech sample changed while stalled");
    a_inputs_open: assert property (enc_in_ready && dec_in_ready)
        else $error("input side refused a word");
endmodule : sch_top_assertions

// ==== testbench/sch_chan_model.sv ====
`timescale 1ns/10ps

module sch_chan_model (
    input  wire logic clk,           // clock
    input  wire logic rstn,          // async reset, active low
    output logic      enc_out_ready, // channel takes parameters
    output logic      dec_out_ready  // sink takes speech
);
    logic [9:0] phase_q; // upper bit picks prompt or slow spans

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase_q       <= 10'h000;
            enc_out_ready <= 1'b0;
            dec_out_ready <= 1'b0;
        end else begin
            phase_q       <= phase_q + 10'h001;
            enc_out_ready <= phase_q[9] ? ($urandom_range(0, 3) == 0) : ($urandom_range(0, 3) != 0);
            dec_out_ready <= phase_q[9] ? ($urandom_range(0, 3) == 0) : ($urandom_range(0, 3) != 0);
        end
    end
endmodule : sch_chan_model

// ==== testbench/speech_codec_homing_test.sv ====
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end

module speech_codec_homing_test;
    import sch_pkg::*;
    logic        clk, rstn, enc_in_valid, enc_in_first, enc_in_ready, enc_core_valid, enc_core_ready;
    logic        enc_out_valid, enc_out_ready, enc_home_pulse, enc_homed, dec_in_valid, dec_in_bad;
    logic        dec_in_ready, dec_synth_valid, dec_synth_ready, dec_out_valid, dec_out_ready;
    logic        dec_home_pulse, dec_homed;
    logic [15:0] enc_in_sample, enc_core_param, enc_out_param, dec_in_param, dec_synth, dec_out_sample;
    logic [15:0] dec_prev_lag, dm;
    logic [15:0] enc_exp[$], enc_got[$], dec_got[$];
    int          miscompares, num_checks, enc_pulses, dec_pulses;

    sch_top dut (.clk, .rstn, .enc_in_sample, .enc_in_valid, .enc_in_first, .enc_in_ready, .enc_core_param,
        .enc_core_valid, .enc_core_ready, .enc_out_param, .enc_out_valid, .enc_out_ready, .enc_home_pulse,
        .enc_homed, .dec_in_param, .dec_in_valid, .dec_in_bad, .dec_in_ready, .dec_synth, .dec_synth_valid,
        .dec_synth_ready, .dec_out_sample, .dec_out_valid, .dec_out_ready, .dec_home_pulse, .dec_prev_lag,
        .dec_homed);
    sch_chan_model u_chan (.clk, .rstn, .enc_out_ready, .dec_out_ready);

    always #2.5 clk = ~clk;

    always @(posedge clk) begin
        if (enc_out_valid && enc_out_ready) enc_got.push_back(enc_out_param);
        if (dec_out_valid && dec_out_ready) dec_got.push_back(dec_out_sample);
        if (enc_home_pulse) enc_pulses++;
        if (dec_home_pulse) dec_pulses++;
    end
    // ======================================================================
    // expectation helpers
    function automatic logic [15:0] home_word(input int i);
        logic [15:0] lar [8] = '{16'h0009, 16'h0017, 16'h000F, 16'h0008, 16'h0007, 16'h0003, 16'h0003, 16'h0002};
        int          s, p;
        s = (i - 8) / 17;
        p = (i - 8) % 17;
        if (i < 8) return lar[i];
        if (p == 0) return 16'h0028;
        if (p < 4) return 16'h0000;
        return (s == 3 && p == 8) ? 16'h0003 : 16'h0004;
    endfunction : home_word

    function automatic logic [15:0] deemph(input logic [15:0] x, input logic [15:0] prev);
        int acc;
        acc = $signed(x) + (($signed(prev) * 28180) >>> 15);
        if (acc > 32767) acc = 32767;
        else if (acc < -32768) acc = -32768;
        return acc[15:0];
    endfunction : deemph
    // ======================================================================
    // drivers
    task automatic put(input int ch, input logic [15:0] w, input logic bad);
        #1;
        case (ch)
            0: begin enc_core_param = w; enc_core_valid = 1'b1; end
            1: begin dec_in_param = w; dec_in_bad = bad; dec_in_valid = 1'b1; end
            default: begin dec_synth = w; dec_synth_valid = 1'b1; end
        endcase
        do @(posedge clk);
        while (!((ch == 0 && enc_core_ready) || (ch == 1 && dec_in_ready) || (ch == 2 && dec_synth_ready)));
    endtask : put

    task automatic idle();
        #1;
        enc_core_valid  = 1'b0;
        dec_in_valid    = 1'b0;
        dec_synth_valid = 1'b0;
    endtask : idle

    task automatic enc_run(input int odd_idx, input logic homed_exp, input int pulses_exp);
        logic [15:0] w;
        for (int i = 0; i < FRAME_SAMPLES; i++) begin
            #1;
            enc_in_valid  = 1'b1;
            enc_in_first  = (i == 0);
            enc_in_sample = (i == odd_idx) ? {13'($urandom_range(2, 8191)), 3'h0} : 16'h0008;
            @(posedge clk);
        end
        #1;
        enc_in_valid = 1'b0;
        for (int i = 0; i < PARAM_COUNT; i++) begin
            w = 16'($urandom);
            enc_exp.push_back(w);
            put(0, w, 1'b0);
        end
        idle();
        for (int k = 0; k < 4000 && enc_got.size() < PARAM_COUNT; k++) @(posedge clk);
        repeat (4) @(posedge clk);
        #1;
        foreach (enc_exp[i]) `CHK(enc_got[i], enc_exp[i])
        `CHK(enc_homed, homed_exp)
        `CHK(enc_pulses, pulses_exp)
        enc_exp.delete();
        enc_got.delete();
    endtask : enc_run

    task automatic dec_run(input logic home, input int bad_idx, input int odd_idx,
                           input logic subst, input logic homed_exp, input int pulses_exp);
        logic [15:0] w;
        logic [15:0] exp_q[$];
        logic [15:0] lag;
        for (int i = 0; i < PARAM_COUNT; i++) begin
            w = home ? home_word(i) : 16'($urandom_range(0, 7));
            if (!home && i == 0) w = 16'($urandom_range(10, 63));
            if (i == odd_idx) w = w ^ 16'h0001;
            if (i == SUB_BASE + 3 * SUB_STRIDE) lag = w;
            put(1, w, i == bad_idx);
        end
        idle();
        for (int i = 0; i < FRAME_SAMPLES; i++) begin
            w  = 16'($urandom);
            dm = deemph(w, dm);
            exp_q.push_back(subst ? 16'h0008 : dm);
            put(2, w, 1'b0);
        end
        idle();
        for (int k = 0; k < 4000 && dec_got.size() < FRAME_SAMPLES; k++) @(posedge clk);
        repeat (4) @(posedge clk);
        #1;
        foreach (exp_q[i]) `CHK(dec_got[i], exp_q[i])
        `CHK(dec_homed, homed_exp)
        `CHK(dec_pulses, pulses_exp)
        if (homed_exp) begin
            dm = 16'h0000;
            `CHK(dec_prev_lag, 16'h0028)
        end else begin
            `CHK(dec_prev_lag, lag)
        end
        dec_got.delete();
    endtask : dec_run

    task automatic finish_test();
        if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    // ======================================================================
    // main sequence
    initial begin
        void'($urandom(32'hFCA2));
        {clk, rstn, enc_in_valid, enc_in_first, enc_core_valid, dec_in_valid, dec_in_bad, dec_synth_valid} = '0;
        {enc_in_sample, enc_core_param, dec_in_param, dec_synth, dm} = '0;
        repeat (2) @(posedge clk);
        #1 rstn = 1'b1;
        `CHK(enc_homed, 1'b1)
        `CHK(dec_homed, 1'b1)
        `CHK(dec_prev_lag, 16'h0028)
        enc_run(-1, 1'b1, 1);
        enc_run(0, 1'b0, 1);
        enc_run(FRAME_SAMPLES - 1, 1'b0, 1);
        enc_run(-1, 1'b1, 2);
        dec_run(1'b1, -1, -1, 1'b1, 1'b1, 1);
        dec_run(1'b1, 10, -1, 1'b0, 1'b0, 1);
        dec_run(1'b0, -1, -1, 1'b0, 1'b0, 1);
        dec_run(1'b1, -1, -1, 1'b0, 1'b1, 2);
        dec_run(1'b1, -1, -1, 1'b1, 1'b1, 3);
        dec_run(1'b1, -1, 40, 1'b1, 1'b1, 4);
        dec_run(1'b1, -1, 24, 1'b0, 1'b0, 4);
        finish_test();
    end

    initial begin
        #250000;
        miscompares++;
        finish_test();
    end
endmodule : speech_codec_homing_test

bind sch_top sch_top_assertions u_chk (.clk, .rstn, .enc_in_ready, .enc_out_param, .enc_out_valid,
    .enc_out_ready, .enc_home_pulse, .enc_homed, .dec_in_ready, .dec_out_sample, .dec_out_valid,
    .dec_out_ready, .dec_home_pulse, .dec_prev_lag, .dec_homed);
